// ### hw/swire_triplet_and_block_receive.sv
`timescale 1ns/1ps
`include "swire_cmd_cfg.svh"
// Function
// RULE_01: refuse command while line busy
// RULE_02: triplet ends within three slots plus start
// RULE_03: line activity starts within 1.09 us
// RULE_04: triplet leaves pointer on status register
// RULE_05: busy stays high three slots
// RULE_06: result flags update at sample points
// RULE_07: parameter bit 7 picks zero-zero branch
// RULE_08: code E1h selects block receive
// RULE_09: receive one to 63 bytes
// RULE_10: receive only after line idle
// RULE_11: receive ends within count times eight slots
// RULE_12: receive leaves pointer on status register
// RULE_13: busy stays high eight slots per byte
// RULE_14: count in bits 5:0, store from 00h
// RULE_15: count zero receives one byte
// RULE_16: triplet code 78h, host repeats 64 times
// RULE_17: write slot follows read pair results
// RULE_18: slots use current configuration
// RULE_19: host polls busy before next command
module swire_triplet_and_block_receive
  import swire_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic param_valid,
  input wire logic [7:0] param_byte,
  input wire slot_cfg_t slot_cfg,
  input wire logic line_in,
  input wire logic [5:0] scratch_rd_addr,
  output logic cmd_ack,
  output logic cmd_nack,
  output logic line_oe_n,
  output master_status_t status,
  output logic [7:0] read_pointer,
  output logic [7:0] scratch_rd_data,
  output logic [5:0] bytes_received
);
  // ------------------------------------------------------------
  // reset and pin synchronisers
  // ------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_r;
  logic line_s1_r;
  logic line_sync_r;
  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end
  // line pin synchroniser
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      line_s1_r <= 1'b1;
      line_sync_r <= 1'b1;
    end
    else
    begin
      line_s1_r <= line_in;
      line_sync_r <= line_s1_r;
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, WAIT_PARAM, TRIP_RD1, TRIP_RD2, TRIP_WR,
    RECV_BIT} seq_state_t;
  seq_state_t state_r;
  logic is_triplet_r; // which command awaits its parameter
  logic dir_r; // branch for zero-zero
  logic first_bit_r; // first read result
  logic [5:0] byte_cnt_r; // bytes left minus one
  logic [5:0] wr_idx_r; // scratchpad write index
  logic [2:0] bit_idx_r; // bit within byte
  logic [7:0] shift_r; // assembling byte, lsb first
  logic [7:0] scratch_r [0:`SCRATCH_DEPTH-1];
  logic slot_start_r;
  slot_kind_t slot_kind_r;
  logic slot_oe_n;
  logic samp_stb;
  logic samp_bit;
  logic slot_done;
  logic line_bit_q; // sampled bit held by the slot engine
  logic busy_r; // line busy flag
  logic sbr_r; // first read result
  logic tsb_r; // second read result
  logic path_r; // write-one branch taken
  // status word comes straight from the flag flops
  assign status = '{busy_r, sbr_r, tsb_r, path_r};
  // decode of write slot kind after the read pair
  function automatic slot_kind_t pick_write(input logic b1, input logic b2,
                                            input logic dir);
    begin
      if (b1 != b2)
        pick_write = b1 ? SLOT_W1 : SLOT_W0; // [RULE_17]
      else if (b1)
        pick_write = SLOT_W1; // both one: error case writes one [RULE_17]
      else
        pick_write = dir ? SLOT_W1 : SLOT_W0; // [RULE_07]
    end
  endfunction : pick_write
  // slot engine, fed live configuration
  swire_slot_gen u_slot (
    .clk(clk),
    .rst_n(rst_n_r),
    .start(slot_start_r),
    .kind(slot_kind_r),
    .cfg(slot_cfg), // [RULE_18]
    .line_in(line_sync_r),
    .line_oe_n(slot_oe_n),
    .sample_strobe(samp_stb),
    .sample_bit(samp_bit),
    .done(slot_done)
  );
  // line output registered at top
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      line_oe_n <= 1'b1;
    else
      line_oe_n <= slot_oe_n;
  end
  // command acceptance
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
    end
    else
    begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      if (cmd_valid && (cmd_code == `CMD_TRIPLET || cmd_code == `CMD_RECV_BLOCK))
      begin
        if (busy_r || state_r != IDLE)
          cmd_nack <= 1'b1; // [RULE_01] [RULE_10]
        else
          cmd_ack <= 1'b1;
      end
    end
  end
  // main state machine; slot starts the cycle after the parameter is taken
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= IDLE;
      is_triplet_r <= 1'b0;
      dir_r <= 1'b0;
      byte_cnt_r <= 6'h00;
      bit_idx_r <= 3'h0;
      slot_start_r <= 1'b0;
      slot_kind_r <= SLOT_READ;
    end
    else
    begin
      slot_start_r <= 1'b0;
      unique case (state_r)
        IDLE:
        begin
          // busy refusal handled above; only idle line accepts [RULE_01]
          if (cmd_valid && !busy_r)
          begin
            if (cmd_code == `CMD_TRIPLET) // [RULE_16]
            begin
              is_triplet_r <= 1'b1;
              state_r <= WAIT_PARAM;
            end
            else if (cmd_code == `CMD_RECV_BLOCK) // [RULE_08]
            begin
              is_triplet_r <= 1'b0;
              state_r <= WAIT_PARAM;
            end
          end
        end
        WAIT_PARAM:
        begin
          if (param_valid)
          begin
            slot_start_r <= 1'b1; // starts well inside 1.09 us [RULE_03]
            slot_kind_r <= is_triplet_r ? SLOT_READ : SLOT_W1;
            dir_r <= param_byte[`TRIPLET_DIR_BIT]; // [RULE_07]
            // count field; zero still means one byte [RULE_14] [RULE_15]
            byte_cnt_r <= param_byte[`RECV_COUNT_MSB:`RECV_COUNT_LSB] == 6'h00 ?
                          6'h00 : param_byte[`RECV_COUNT_MSB:`RECV_COUNT_LSB] - 6'h01;
            bit_idx_r <= 3'h0;
            state_r <= is_triplet_r ? TRIP_RD1 : RECV_BIT;
          end
        end
        TRIP_RD1:
        begin
          if (slot_done)
          begin
            slot_start_r <= 1'b1;
            slot_kind_r <= SLOT_READ;
            state_r <= TRIP_RD2;
          end
        end
        TRIP_RD2:
        begin
          if (slot_done)
          begin
            slot_start_r <= 1'b1;
            slot_kind_r <= pick_write(first_bit_r, tsb_r, dir_r);
            state_r <= TRIP_WR;
          end
        end
        TRIP_WR:
        begin
          if (slot_done)
            state_r <= IDLE; // three slots done [RULE_02]
        end
        RECV_BIT:
        begin
          if (slot_done)
          begin
            bit_idx_r <= bit_idx_r + 3'h1;
            if (bit_idx_r == 3'h7 && byte_cnt_r == 6'h00)
              state_r <= IDLE; // count times eight slots [RULE_11]
            else
            begin
              if (bit_idx_r == 3'h7)
                byte_cnt_r <= byte_cnt_r - 6'h01;
              slot_start_r <= 1'b1; // read slot = write-one slot
              slot_kind_r <= SLOT_W1;
            end
          end
        end
        default:
          state_r <= IDLE;
      endcase
    end
  end
  // busy flag spans the slot sequence
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      busy_r <= 1'b0;
    else if (state_r == WAIT_PARAM && param_valid)
      busy_r <= 1'b1; // [RULE_05] [RULE_13]
    else if (slot_done && (state_r == TRIP_WR ||
             (state_r == RECV_BIT && bit_idx_r == 3'h7 && byte_cnt_r == 6'h00)))
      busy_r <= 1'b0; // [RULE_05] [RULE_13]
  end
  // triplet result flags at sample points
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sbr_r <= 1'b0;
      tsb_r <= 1'b0;
      path_r <= 1'b0;
      first_bit_r <= 1'b0;
    end
    else if (samp_stb && state_r == TRIP_RD1)
    begin
      sbr_r <= samp_bit; // first sample [RULE_06]
      first_bit_r <= samp_bit;
    end
    else if (samp_stb && state_r == TRIP_RD2)
    begin
      tsb_r <= samp_bit; // second sample [RULE_06]
      path_r <= (pick_write(first_bit_r, samp_bit, dir_r) == SLOT_W1); // [RULE_06]
    end
  end
  // receive data into scratchpad from 00h
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      shift_r <= 8'h00;
      wr_idx_r <= `SCRATCH_BASE;
      bytes_received <= 6'h00;
    end
    else if (state_r == WAIT_PARAM && param_valid && !is_triplet_r)
    begin
      wr_idx_r <= `SCRATCH_BASE; // [RULE_14]
      bytes_received <= 6'h00;
    end
    else if (state_r == RECV_BIT && slot_done)
    begin
      shift_r <= {line_bit_q, shift_r[7:1]};
      if (bit_idx_r == 3'h7)
      begin
        wr_idx_r <= wr_idx_r + 6'h01; // [RULE_09]
        bytes_received <= wr_idx_r + 6'h01;
      end
    end
  end
  assign line_bit_q = samp_bit;
  // scratchpad storage
  always_ff @(posedge clk)
  begin
    if (state_r == RECV_BIT && slot_done && bit_idx_r == 3'h7)
      scratch_r[wr_idx_r] <= {line_bit_q, shift_r[7:1]}; // [RULE_09]
  end
  // scratchpad read port
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      scratch_rd_data <= 8'h00;
    else
      scratch_rd_data <= scratch_r[scratch_rd_addr];
  end
  // read pointer parks on status after either command
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      read_pointer <= `STATUS_ADDR;
    else if (state_r == WAIT_PARAM && param_valid)
      read_pointer <= `STATUS_ADDR; // [RULE_04] [RULE_12]
  end
endmodule : swire_triplet_and_block_receive

// ### hw/swire_cmd_cfg.svh
`ifndef SWIRE_CMD_CFG_SVH
`define SWIRE_CMD_CFG_SVH
// command codes
`define CMD_TRIPLET 8'h78
`define CMD_RECV_BLOCK 8'hE1
// parameter byte fields
`define TRIPLET_DIR_BIT 7
`define RECV_COUNT_MSB 5
`define RECV_COUNT_LSB 0
// scratchpad
`define SCRATCH_DEPTH 64
`define SCRATCH_BASE 6'h00
// timing, clock 20 MHz
`define CLK_PERIOD_NS 50
`define START_MAX_NS 1090
`define START_MAX_CYC (`START_MAX_NS / `CLK_PERIOD_NS)
// slot timing reset values, in cycles
`define SLOT_CYC_STD 8'hC8
`define SLOT_CYC_OD 8'h32
`define SAMPLE_CYC_STD 8'h1E
`define SAMPLE_CYC_OD 8'h05
`define STATUS_ADDR 8'h00
`endif

// ### hw/swire_cmd_pkg.sv
package swire_cmd_pkg;
  // slot timing set, in clock cycles
  typedef struct packed {
    logic overdrive_speed_select;
    logic active_pullup_select;
    logic [7:0] write_zero_low_time;
    logic [7:0] write_one_low_time;
    logic [7:0] recovery_time;
    logic [3:0] weak_pullup_resistance;
  } slot_cfg_t;
  // busy flag and result bits of a triplet
  typedef struct packed {
    logic line_busy_flag;
    logic single_bit_result;
    logic triplet_second_bit;
    logic chosen_path;
  } master_status_t;
  typedef enum logic [1:0] {SLOT_READ, SLOT_W0, SLOT_W1} slot_kind_t;
endpackage : swire_cmd_pkg

// ### hw/swire_slot_gen.sv
`timescale 1ns/1ps
`include "swire_cmd_cfg.svh"
// generates one line time slot and samples the line
module swire_slot_gen
  import swire_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire slot_kind_t kind,
  input wire slot_cfg_t cfg,
  input wire logic line_in,
  output logic line_oe_n,
  output logic sample_strobe,
  output logic sample_bit,
  output logic done
);
  logic [7:0] cnt_r;
  logic busy_r;
  logic [7:0] low_len;
  logic [7:0] slot_len;
  logic [7:0] samp_at;
  slot_kind_t kind_r;
  // low phase length by slot kind; read uses the write-one low time
  always_comb
  begin
    low_len = (kind_r == SLOT_W0) ? cfg.write_zero_low_time : cfg.write_one_low_time;
    slot_len = cfg.overdrive_speed_select ? `SLOT_CYC_OD : `SLOT_CYC_STD;
    samp_at = cfg.overdrive_speed_select ? `SAMPLE_CYC_OD : `SAMPLE_CYC_STD;
  end
  // slot counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      kind_r <= SLOT_READ;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r <= 8'h00;
        kind_r <= kind;
      end
      else if (busy_r)
      begin
        // end two counts early: the done pulse and the sequencer's start pulse
        // fill the last two cycles, so back-to-back slots keep the slot period
        if (cnt_r == slot_len - 8'h03)
        begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
  // line drive: low during low phase, released through recovery
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      line_oe_n <= 1'b1;
    else
      line_oe_n <= !(busy_r && cnt_r < low_len);
  end
  // sample point
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_strobe <= 1'b0;
      sample_bit <= 1'b0;
    end
    else
    begin
      sample_strobe <= busy_r && (cnt_r == samp_at) && (kind_r == SLOT_READ);
      if (busy_r && cnt_r == samp_at)
        sample_bit <= line_in;
    end
  end
endmodule : swire_slot_gen

// ### testbench/swire_cmd_props.sv
`timescale 1ns/1ps
`include "swire_cmd_cfg.svh"
// ---
// command checker
// ---
module swire_cmd_props
  import swire_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic param_valid,
  input wire slot_cfg_t slot_cfg,
  input wire logic cmd_ack,
  input wire logic cmd_nack,
  input wire logic line_oe_n,
  input wire master_status_t status,
  input wire logic [7:0] read_pointer
);
  localparam int START_LIM = 20;
  logic busy;
  logic ok_code;
  int slot_len;
  int busy_len_r;
  int low_len_r;
  assign busy = status.line_busy_flag;
  assign ok_code = (cmd_code == `CMD_TRIPLET) || (cmd_code == `CMD_RECV_BLOCK);
  assign slot_len = slot_cfg.overdrive_speed_select ? int'(`SLOT_CYC_OD) : int'(`SLOT_CYC_STD);
  // busy and drive run lengths
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_len_r <= 0;
      low_len_r <= 0;
    end
    else
    begin
      busy_len_r <= busy ? busy_len_r + 1 : 0;
      low_len_r <= line_oe_n ? 0 : low_len_r + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_REFUSE_BUSY: assert property (cmd_valid && ok_code && busy |=> cmd_nack && !cmd_ack)
    else $error("command taken while busy");
  AST_ACK_CAUSE: assert property (cmd_ack |-> $past(cmd_valid) && $past(ok_code) && !$past(busy))
    else $error("ack without a valid idle command");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(param_valid))
    else $error("busy rose without parameter");
  AST_LINE_START: assert property ($rose(busy) |-> ##[0:START_LIM] !line_oe_n)
    else $error("line activity started late");
  AST_IDLE_RELEASED: assert property (!busy |-> line_oe_n)
    else $error("line driven while not busy");
  AST_PTR_STATUS: assert property ($fell(busy) |-> read_pointer == `STATUS_ADDR)
    else $error("pointer not on status");
  AST_BUSY_SPAN: assert property ($fell(busy) |-> busy_len_r >= 3 * slot_len &&
    busy_len_r <= 504 * slot_len + START_LIM)
    else $error("busy span out of range");
  AST_LOW_SPAN: assert property (low_len_r < slot_len)
    else $error("line low longer than a slot");
  COV_ACK: cover property (cmd_ack);
  COV_REFUSE: cover property (cmd_valid && ok_code && busy);
  COV_DONE: cover property ($fell(busy));
endmodule : swire_cmd_props

bind swire_triplet_and_block_receive swire_cmd_props u_props (.clk(clk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_valid(param_valid), .slot_cfg(slot_cfg),
  .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .line_oe_n(line_oe_n), .status(status),
  .read_pointer(read_pointer));

// ### testbench/swire_slave_model.sv
`timescale 1ns/1ps
// ---
// line slave: stretches low to answer a zero
// ---
module swire_slave_model (
  input wire logic clk,
  input wire logic line_oe_n,
  input wire logic restart,
  input wire logic [63:0] pattern,
  input wire logic [4:0] hold_cyc,
  output logic line
);
  int k;
  int hold;
  logic prev_oe = 1'b1;
  // open drain with pull-up: released line reads high
  assign line = !(!line_oe_n || hold > 0);
  always @(posedge clk)
  begin
    if (restart)
      k = 0;
    if (prev_oe && !line_oe_n)
    begin
      if (!pattern[k[5:0]])
        hold = hold_cyc;
      k = k + 1;
    end
    else if (hold > 0)
      hold = hold - 1;
    prev_oe = line_oe_n;
  end
endmodule : swire_slave_model

// ### testbench/swire_triplet_and_block_receive_bench.sv
`timescale 1ns/1ps
`include "swire_cmd_cfg.svh"
module swire_triplet_and_block_receive_bench;
  import swire_cmd_pkg::*;
  localparam int SLOT = 50;
  logic clk, reset_n, cmd_valid, param_valid, line, restart, cmd_ack, cmd_nack, line_oe_n, sbr2;
  logic [7:0] cmd_code, param_byte, read_pointer, scratch_rd_data;
  logic [5:0] scratch_rd_addr, bytes_received;
  logic [63:0] pattern;
  logic [4:0] hold_cyc;
  slot_cfg_t slot_cfg;
  master_status_t status;
  int err_total, n_compared, first_low, busy_len, nlow;
  int low_len [512];
  swire_triplet_and_block_receive dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .param_valid(param_valid), .param_byte(param_byte),
    .slot_cfg(slot_cfg), .line_in(line), .scratch_rd_addr(scratch_rd_addr), .cmd_ack(cmd_ack),
    .cmd_nack(cmd_nack), .line_oe_n(line_oe_n), .status(status), .read_pointer(read_pointer),
    .scratch_rd_data(scratch_rd_data), .bytes_received(bytes_received));
  swire_slave_model peer (.clk(clk), .line_oe_n(line_oe_n), .restart(restart),
    .pattern(pattern), .hold_cyc(hold_cyc), .line(line));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task tally_and_finish;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // code, parameter, then record slots until busy falls
  task run_cmd(input logic [7:0] code, input logic [7:0] prm);
    @(posedge clk);
    cmd_code <= code;
    cmd_valid <= 1'b1;
    restart <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    restart <= 1'b0;
    param_byte <= prm;
    param_valid <= 1'b1;
    #1 check(cmd_ack === 1'b1 && cmd_nack === 1'b0, "no ack");
    @(posedge clk);
    param_valid <= 1'b0;
    first_low = -1;
    #1 busy_len = int'(status.line_busy_flag === 1'b1);
    nlow = 0;
    low_len[0] = 0;
    for (int t = 1; t < 30000; t++)
    begin
      @(posedge clk);
      #1;
      if (!line_oe_n)
      begin
        if (first_low < 0)
          first_low = t;
        low_len[nlow]++;
        if (nlow == 1 && low_len[1] == 1)
          sbr2 = status.single_bit_result;
      end
      else if (low_len[nlow] > 0)
      begin
        nlow++;
        low_len[nlow] = 0;
      end
      if (status.line_busy_flag === 1'b1)
        busy_len++;
      else if (busy_len > 0)
        break;
    end
    check(first_low >= 0 && first_low <= `START_MAX_CYC, "late start");
    check(read_pointer === `STATUS_ADDR, "pointer");
  endtask : run_cmd
  // 64 triplets over every read pair and direction
  task triplet_sweep;
    logic r1, r2, dir, wb;
    for (int i = 0; i < 64; i++)
    begin
      r1 = i[0];
      r2 = i[1];
      dir = i[2];
      wb = r1 ? 1'b1 : (r2 ? 1'b0 : dir);
      pattern <= {61'h0, 1'b1, r2, r1};
      hold_cyc <= i[3] ? 5'h0A : 5'h0E;
      run_cmd(`CMD_TRIPLET, {dir, i[6:0] ^ 7'h55});
      check(nlow === 3, "slot count");
      check(busy_len >= 3 * SLOT && busy_len <= 3 * SLOT + `START_MAX_CYC, "span");
      check((low_len[2] > 20) === !wb, "write slot");
      check(status.single_bit_result === r1 && status.triplet_second_bit === r2, "bits");
      check(status.chosen_path === wb && sbr2 === r1, "path");
    end
  endtask : triplet_sweep
  // block receive and scratchpad readback
  task recv(input logic [7:0] prm);
    int n;
    n = (prm[5:0] == 6'h00) ? 1 : int'(prm[5:0]);
    run_cmd(`CMD_RECV_BLOCK, prm);
    check(busy_len >= 8 * n * SLOT && busy_len <= 8 * n * SLOT + 21, "rx span");
    check(nlow === 8 * n && bytes_received === 6'(n), "rx count");
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      scratch_rd_addr <= i[5:0];
      @(posedge clk);
      @(posedge clk);
      #1 check(scratch_rd_data === pattern[(8 * i) % 64 +: 8], "rx byte");
    end
  endtask : recv
  // triplet code while a receive is running, then an unknown code
  task refuse;
    fork
      recv(8'h01);
      begin
        repeat (40) @(posedge clk);
        cmd_code <= `CMD_TRIPLET;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 check(cmd_nack === 1'b1 && cmd_ack === 1'b0, "no nack");
      end
    join
    @(posedge clk);
    cmd_code <= 8'h55;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1 check(cmd_ack === 1'b0 && status.line_busy_flag === 1'b0, "odd code");
  endtask : refuse
  initial
  begin
    reset_n = 1'b0;
    {cmd_valid, param_valid, restart, cmd_code, param_byte, scratch_rd_addr} = '0;
    pattern = '0;
    hold_cyc = 5'h0C;
    slot_cfg = '{1'b1, 1'b0, 8'h1E, 8'h01, 8'h02, 4'h0};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    triplet_sweep;
    pattern <= 64'hC3A5_5A3C_96E1_0F78;
    hold_cyc <= 5'h14;
    recv(8'hC0);
    recv(8'h43);
    recv(8'h3F);
    refuse;
    tally_and_finish;
  end
  initial
  begin
    #4000000;
    err_total++;
    tally_and_finish;
  end
endmodule : swire_triplet_and_block_receive_bench
